// ### hdl/deepc_pkg.sv
`default_nettype none
package deepc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [15:0] CTRL_OFS = 16'h0760;
  localparam logic [15:0] ADDR_LO_OFS = 16'h0762;
  localparam logic [15:0] ADDR_HI_OFS = 16'h0764;
  localparam logic [15:0] KEY_OFS = 16'h0766;
  localparam logic [15:0] DONE_OFS = 16'h0768;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int START_POS = 15;
  localparam int PERMIT_POS = 14;
  localparam int FAULT_POS = 13;
  localparam int DONE_POS = 0;
  localparam int OP_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Operation codes and unlock keys
  localparam logic [6:0] OP_ERASE_BLOCK = 7'h45;
  localparam logic [6:0] OP_ERASE_WORD = 7'h44;
  localparam logic [6:0] OP_PROGRAM_WORD = 7'h04;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [23:0] EE_BASE = 24'h7FFC00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CYCLE_TIME_MS = 2;
  localparam int NS_PER_MS = 1000000;
  localparam int OP_CYCLES_DEFAULT = (CYCLE_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // State types
  typedef enum logic [1:0] {key_idle, key_half, key_open} deepc_key_type;

  typedef struct packed {
    logic start_bit;
    logic permit;
    logic fault;
    logic [6:0] op;
    logic [15:0] addr_lo;
    logic [7:0] addr_hi;
    logic [15:0] latch;
    deepc_key_type key;
    logic done_flag;
    logic [15:0] rdata;
    logic nv_start;
    logic [6:0] nv_op;
  } deepc_state_type;

  localparam deepc_state_type STATE_RST = '0;

endpackage
`default_nettype wire

// ### hdl/deepc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module deepc_timer #(
  parameter int unsigned CYCLES = 4,
  parameter int CNT_W = 3
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
  } deepc_tmr_type;

  deepc_tmr_type s;
  deepc_tmr_type next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Countdown
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (abort) begin
      next_s = '0;
    end else if (start && !s.busy) begin
      next_s.busy = 1'b1;
      next_s.cnt = CNT_W'(CYCLES - 2);
    end else if (s.busy) begin
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;

endmodule
`default_nettype wire

// ### hdl/deepc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module deepc_ctrl #(
  parameter int unsigned OP_CYCLES = deepc_pkg::OP_CYCLES_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic table_store_low_instr,
  input wire logic [23:0] table_store_addr,
  input wire logic [15:0] table_store_data,
  input wire logic warm_reset,
  output logic eeprom_done_flag,
  output logic nv_start,
  output logic [6:0] nv_op,
  output logic [23:0] nv_addr,
  output logic [15:0] nv_data,
  output logic nv_busy
);

  localparam int CNT_W = $clog2(OP_CYCLES + 1);

  if (OP_CYCLES < 2) begin
    $error("OP_CYCLES must be at least 2");
  end

  deepc_pkg::deepc_state_type s;
  deepc_pkg::deepc_state_type next_s;
  logic launch;
  logic tmr_busy;
  logic tmr_done;
  logic op_ok;
  logic ee_space;
  logic ctrl_wr;
  logic key_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle timer
  deepc_timer #(
    .CYCLES(OP_CYCLES),
    .CNT_W(CNT_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(launch),
    .abort(warm_reset),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    next_s.nv_start = 1'b0;
    next_s.rdata = 16'h0000;
    ctrl_wr = reg_wr && (reg_addr == deepc_pkg::CTRL_OFS);
    key_wr = reg_wr && (reg_addr == deepc_pkg::KEY_OFS);
    op_ok = (reg_wdata[deepc_pkg::OP_W-1:0] == deepc_pkg::OP_ERASE_BLOCK) ||
            (reg_wdata[deepc_pkg::OP_W-1:0] == deepc_pkg::OP_ERASE_WORD) ||
            (reg_wdata[deepc_pkg::OP_W-1:0] == deepc_pkg::OP_PROGRAM_WORD);
    ee_space = table_store_addr >= deepc_pkg::EE_BASE;
    // Start only from an opened key, an earlier permit and an idle engine
    launch = ctrl_wr && reg_wdata[deepc_pkg::START_POS] && (s.key == deepc_pkg::key_open) &&
             s.permit && op_ok && !s.start_bit && !warm_reset;

    // Key sequencer
    if (key_wr) begin
      if (reg_wdata[7:0] == deepc_pkg::KEY_FIRST) begin
        next_s.key = deepc_pkg::key_half;
      end else if (reg_wdata[7:0] == deepc_pkg::KEY_SECOND && s.key == deepc_pkg::key_half) begin
        next_s.key = deepc_pkg::key_open;
      end else begin
        next_s.key = deepc_pkg::key_idle;
      end
    end else if (reg_wr || reg_rd) begin
      next_s.key = deepc_pkg::key_idle;
    end

    // Control writes
    if (ctrl_wr) begin
      next_s.permit = reg_wdata[deepc_pkg::PERMIT_POS];
      if (!reg_wdata[deepc_pkg::FAULT_POS]) begin
        next_s.fault = 1'b0;
      end
      if (!s.start_bit) begin
        next_s.op = reg_wdata[deepc_pkg::OP_W-1:0];
      end
    end
    if (launch) begin
      next_s.start_bit = 1'b1;
      next_s.nv_start = 1'b1;
      next_s.nv_op = reg_wdata[deepc_pkg::OP_W-1:0];
    end

    // Address registers from software while idle
    if (reg_wr && reg_addr == deepc_pkg::ADDR_LO_OFS && !s.start_bit) begin
      next_s.addr_lo = reg_wdata;
    end
    if (reg_wr && reg_addr == deepc_pkg::ADDR_HI_OFS && !s.start_bit) begin
      next_s.addr_hi = reg_wdata[7:0];
    end

    // Table write loads the latch and captures its address
    if (table_store_low_instr && ee_space && !s.start_bit) begin
      next_s.latch = table_store_data;
      next_s.addr_lo = table_store_addr[15:0];
      next_s.addr_hi = table_store_addr[23:16];
    end

    // Done flag, hardware set beats software clear
    if (reg_wr && reg_addr == deepc_pkg::DONE_OFS && reg_wdata[deepc_pkg::DONE_POS]) begin
      next_s.done_flag = 1'b0;
    end
    if (tmr_done) begin
      next_s.start_bit = 1'b0;
      next_s.done_flag = 1'b1;
    end

    // Register reads
    if (reg_rd) begin
      unique case (reg_addr)
        deepc_pkg::CTRL_OFS: begin
          next_s.rdata = {s.start_bit, s.permit, s.fault, 6'h00, s.op};
        end
        deepc_pkg::ADDR_LO_OFS: begin
          next_s.rdata = s.addr_lo;
        end
        deepc_pkg::ADDR_HI_OFS: begin
          next_s.rdata = {8'h00, s.addr_hi};
        end
        deepc_pkg::DONE_OFS: begin
          next_s.rdata = {15'h0000, s.done_flag};
        end
        default: begin
          next_s.rdata = 16'h0000;
        end
      endcase
    end

    // Warm reset aborts a cycle, keeps address and latch
    if (warm_reset) begin
      next_s.fault = s.fault || s.start_bit;
      next_s.start_bit = 1'b0;
      next_s.permit = 1'b0;
      next_s.op = 7'h00;
      next_s.key = deepc_pkg::key_idle;
      next_s.nv_start = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= deepc_pkg::STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = s.rdata;
  assign eeprom_done_flag = s.done_flag;
  assign nv_start = s.nv_start;
  assign nv_op = s.nv_op;
  assign nv_addr = {s.addr_hi, s.addr_lo};
  assign nv_data = s.latch;
  assign nv_busy = s.start_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  int run_len;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_len <= 0;
    end else if (s.start_bit) begin
      run_len <= run_len + 1;
    end else begin
      run_len <= 0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence seq_key_pair;
    (key_wr && reg_wdata[7:0] == deepc_pkg::KEY_FIRST) ##1 (key_wr && reg_wdata[7:0] == deepc_pkg::KEY_SECOND);
  endsequence

  sequence seq_start_ok;
    ctrl_wr && reg_wdata[deepc_pkg::START_POS] && s.permit && op_ok && !s.start_bit && !warm_reset;
  endsequence

  a_unlock_launch:
  assert property (seq_key_pair ##1 seq_start_ok |=> s.start_bit && s.nv_start)
    else $error("unlocked start did not launch");

  a_start_key_open:
  assert property ($rose(s.start_bit) |-> $past(s.key == deepc_pkg::key_open) && $past(ctrl_wr))
    else $error("start rose without opened key");

  a_start_permit:
  assert property ($rose(s.start_bit) |-> $past(s.permit))
    else $error("start rose without earlier permit");

  a_op_select:
  assert property ($rose(s.start_bit) |-> s.nv_start && s.nv_op == $past(reg_wdata[6:0]) &&
                   (s.nv_op == deepc_pkg::OP_ERASE_BLOCK || s.nv_op == deepc_pkg::OP_ERASE_WORD ||
                    s.nv_op == deepc_pkg::OP_PROGRAM_WORD))
    else $error("launched with wrong operation code");

  a_cycle_length:
  assert property ($fell(s.start_bit) && !$past(warm_reset) |-> run_len == OP_CYCLES)
    else $error("cycle length differs from timer count");

  a_done_on_end:
  assert property ($fell(s.start_bit) && !$past(warm_reset) |-> s.done_flag)
    else $error("done flag not set at cycle end");

  a_permit_kept:
  assert property ($fell(s.permit) |-> $past(warm_reset) || $past(ctrl_wr && !reg_wdata[deepc_pkg::PERMIT_POS]))
    else $error("permit cleared without software");

  a_permit_no_stop:
  assert property (s.start_bit && !s.permit && !warm_reset && !tmr_done |=> s.start_bit)
    else $error("cycle stopped by clearing permit");

  a_start_no_clear:
  assert property (s.start_bit && ctrl_wr && !reg_wdata[deepc_pkg::START_POS] && !warm_reset && !tmr_done
                   |=> s.start_bit)
    else $error("software cleared start");

  a_fault_abort:
  assert property (warm_reset && s.start_bit |=> s.fault && !s.start_bit && $stable(nv_addr))
    else $error("warm reset abort handled wrongly");

  a_latch_load:
  assert property (table_store_low_instr && ee_space && !s.start_bit |=>
                   nv_data == $past(table_store_data) && nv_addr == $past(table_store_addr))
    else $error("table write not latched");

  a_done_sticky:
  assert property (tmr_done |=> s.done_flag ##1 (s.done_flag || $past(reg_wr && reg_addr == deepc_pkg::DONE_OFS)))
    else $error("done flag lost");

  a_timer_inside:
  assert property (tmr_busy |-> s.start_bit)
    else $error("timer running without start bit");

  a_read_idle_zero:
  assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read");

  a_read_start:
  assert property (reg_rd && reg_addr == deepc_pkg::CTRL_OFS |=> reg_rdata[15] == $past(s.start_bit))
    else $error("start bit read back wrong");

endmodule
`default_nettype wire

// ### test/test_deepc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("MISMATCH %s exp=%h got=%h", name, exp, got); \
  end \
end
module test_deepc_ctrl;
  localparam int OPC = 10;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic tsl = 1'b0;
  logic [23:0] ts_addr = '0;
  logic [15:0] ts_data = '0;
  logic warm_reset = 1'b0;
  logic done_flag, nv_start, nv_busy;
  logic [6:0] nv_op;
  logic [23:0] nv_addr;
  logic [15:0] nv_data, rv;
  int fail_count = 0;
  int check_count = 0;

  int start_seen = 0;

  deepc_ctrl #(
    .OP_CYCLES(OPC)
  ) u_dut (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .table_store_low_instr(tsl),
    .table_store_addr(ts_addr),
    .table_store_data(ts_data),
    .warm_reset(warm_reset),
    .eeprom_done_flag(done_flag),
    .nv_start(nv_start),
    .nv_op(nv_op),
    .nv_addr(nv_addr),
    .nv_data(nv_data),
    .nv_busy(nv_busy)
  );

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (nv_start === 1'b1) start_seen <= start_seen + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus helpers
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic unlock_start(input logic [15:0] ctrl);
    wr(deepc_pkg::KEY_OFS, {8'h00, deepc_pkg::KEY_FIRST});
    wr(deepc_pkg::KEY_OFS, {8'h00, deepc_pkg::KEY_SECOND});
    wr(deepc_pkg::CTRL_OFS, ctrl);
    #1;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 40 && nv_busy; i++) @(posedge sys_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset_values();
    rd(deepc_pkg::CTRL_OFS, rv);
    `CHK("ctrl after reset", 16'h0000, rv)
    `CHK("rdata after read", 16'h0000, reg_rdata)
    `CHK("busy after reset", 1'b0, nv_busy)
    `CHK("done after reset", 1'b0, done_flag)
  endtask

  task automatic test_block_erase();
    int s0;
    s0 = start_seen;
    wr(deepc_pkg::ADDR_HI_OFS, 16'h007F);
    wr(deepc_pkg::ADDR_LO_OFS, 16'hFC20);
    wr(deepc_pkg::CTRL_OFS, 16'h4045);
    unlock_start(16'hC045);
    `CHK("block busy", 1'b1, nv_busy)
    `CHK("block op", 7'h45, nv_op)
    `CHK("block addr", 24'h7FFC20, nv_addr)
    `CHK("block start pulse", s0 + 1, start_seen)
    repeat (OPC - 2) @(posedge sys_clk);
    #1 `CHK("busy last cycle", 1'b1, nv_busy)
    @(posedge sys_clk);
    #1 `CHK("busy ended", 1'b0, nv_busy)
    `CHK("done set", 1'b1, done_flag)
    repeat (3) @(posedge sys_clk);
    #1 `CHK("done stays", 1'b1, done_flag)
    rd(deepc_pkg::CTRL_OFS, rv);
    `CHK("permit kept", 16'h4045, rv)
    wr(deepc_pkg::DONE_OFS, 16'h0001);
    #1 `CHK("done cleared", 1'b0, done_flag)
  endtask

  task automatic test_word_erase_busy();
    wr(deepc_pkg::CTRL_OFS, 16'h4044);
    unlock_start(16'hC044);
    `CHK("word op", 7'h44, nv_op)
    rd(deepc_pkg::CTRL_OFS, rv);
    `CHK("start reads busy", 16'hC044, rv)
    wr(deepc_pkg::CTRL_OFS, 16'h0044);
    rd(deepc_pkg::CTRL_OFS, rv);
    `CHK("start kept permit off", 16'h8044, rv)
    wait_idle();
    `CHK("word done", 1'b1, done_flag)
    wr(deepc_pkg::DONE_OFS, 16'h0001);
  endtask

  task automatic test_program_word();
    int s0;
    tsl <= 1'b1;
    ts_addr <= 24'h7FFC40;
    ts_data <= 16'hBEEF;
    @(posedge sys_clk);
    tsl <= 1'b0;
    @(posedge sys_clk);
    #1 `CHK("latch data", 16'hBEEF, nv_data)
    `CHK("latch addr", 24'h7FFC40, nv_addr)
    tsl <= 1'b1;
    ts_addr <= 24'h001000;
    ts_data <= 16'h1234;
    @(posedge sys_clk);
    tsl <= 1'b0;
    @(posedge sys_clk);
    #1 `CHK("outside space kept", 16'hBEEF, nv_data)
    s0 = start_seen;
    wr(deepc_pkg::CTRL_OFS, 16'h4004);
    unlock_start(16'hC004);
    `CHK("prog op", 7'h04, nv_op)
    `CHK("prog busy", 1'b1, nv_busy)
    `CHK("prog pulse", s0 + 1, start_seen)
    wait_idle();
    `CHK("prog done", 1'b1, done_flag)
    wr(deepc_pkg::DONE_OFS, 16'h0001);
  endtask

  task automatic test_bad_unlock();
    int s0;
    s0 = start_seen;
    wr(deepc_pkg::CTRL_OFS, 16'h4044);
    wr(deepc_pkg::KEY_OFS, 16'h0055);
    rd(deepc_pkg::KEY_OFS, rv);
    wr(deepc_pkg::KEY_OFS, 16'h00AA);
    wr(deepc_pkg::CTRL_OFS, 16'hC044);
    #1 `CHK("broken key no launch", 1'b0, nv_busy)
    wr(deepc_pkg::CTRL_OFS, 16'h0044);
    unlock_start(16'hC044);
    `CHK("same write permit", 1'b0, nv_busy)
    `CHK("no start pulses", s0, start_seen)
  endtask

  task automatic test_warm_reset();
    wr(deepc_pkg::CTRL_OFS, 16'h4044);
    unlock_start(16'hC044);
    `CHK("warm launch", 1'b1, nv_busy)
    warm_reset <= 1'b1;
    @(posedge sys_clk);
    warm_reset <= 1'b0;
    @(posedge sys_clk);
    #1 `CHK("warm aborted", 1'b0, nv_busy)
    `CHK("warm addr kept", 24'h7FFC40, nv_addr)
    rd(deepc_pkg::CTRL_OFS, rv);
    `CHK("fault set", 16'h2000, rv)
    wr(deepc_pkg::CTRL_OFS, 16'h0000);
    rd(deepc_pkg::CTRL_OFS, rv);
    `CHK("fault cleared", 16'h0000, rv)
  endtask

  task automatic test_mid_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    #1 `CHK("mid reset busy", 1'b0, nv_busy)
    `CHK("mid reset addr", 24'h000000, nv_addr)
    rd(deepc_pkg::CTRL_OFS, rv);
    `CHK("mid reset ctrl", 16'h0000, rv)
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    test_reset_values();
    test_block_erase();
    test_word_erase_busy();
    test_program_word();
    test_bad_unlock();
    test_warm_reset();
    test_mid_reset();
    test_done();
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
